// file: eeprom_spi_pkg.sv
// Constants and types shared by the serial EEPROM pin interface.
// Assumes one core clock of 25 MHz and a serial clock from an outside master.
package eeprom_spi_pkg;

  localparam int ADDR_W      = 12;
  localparam int ARRAY_WORDS = 4096;
  localparam int ID_WORDS    = 32;
  localparam int COL_W       = 5;
  localparam int CNT_W       = 6;
  localparam int CTL_W       = 10;

  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WR_ID = 8'h82;
  localparam logic [7:0] OP_RD_ID = 8'h83;

  // Address bit that turns an identification-page write into the lock command
  localparam int LOCK_ADDR_BIT = 10;

  // Status byte layout and control vector handed to the serial side
  localparam int ST_WIP      = 0;
  localparam int ST_WEL      = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam int CTL_LOCKED  = 8;
  localparam int CTL_ARMED   = 9;

  localparam logic [1:0] GUARD_RST = 2'h0;

  localparam int CORE_CLK_HZ       = 25_000_000;
  localparam int WRITE_TIME_MS     = 5;
  localparam int WRITE_CYCLES      = WRITE_TIME_MS * (CORE_CLK_HZ / 1000);
  localparam int WRITE_STEP_CYCLES = 2;
  localparam int WBUF_DEPTH        = 2;

  typedef enum logic [2:0] {
    COMMIT_NONE, COMMIT_WREN, COMMIT_WRDI, COMMIT_WRSR,
    COMMIT_WRITE, COMMIT_WR_ID, COMMIT_LOCK
  } commit_t;

  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR, PH_DATA_IN, PH_DATA_OUT, PH_STATUS_OUT, PH_IGNORE
  } phase_t;

  typedef struct packed {
    logic              id;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } wr_word_t;

endpackage

// file: eeprom_spi_top.sv
// Serial EEPROM pin interface: serial-clock front end and core-clock array.
// Assumes an SPI master in mode 0 or 3; the serial clock only runs in frames.
`timescale 1ns/1ns

module eeprom_spi_link
  import eeprom_spi_pkg::*;
(
  input  wire logic                       spi_clk,
  input  wire logic                       cs_n,
  input  wire logic                       hold_n,
  input  wire logic                       di,
  input  wire logic                       held_rst,
  input  wire logic [CTL_W-1:0]           ctl,
  input  wire logic [7:0]                 rd_byte,
  output logic      [ADDR_W-1:0]          rd_addr,
  output logic                            rd_id,
  output logic                            tag,
  output commit_t                         op,
  output logic                            aligned,
  output logic      [ADDR_W-1:0]          wr_addr,
  output logic                            wr_id,
  output logic      [CNT_W-1:0]           nbytes,
  output logic      [ID_WORDS-1:0][7:0]   page,
  output logic                            q,
  output logic                            q_oe_n
);

  typedef struct packed {
    logic             started;
    logic [2:0]       bitpos;
    logic             addr_hi_done;
    phase_t           phase;
    logic [7:0]       opcode;
    logic [7:0]       sh;
    logic [15:0]      a16;
    logic             id_sel;
    logic [COL_W-1:0] col;
    logic [7:0]       out_byte;
    logic [CTL_W-1:0] ctl_s1;
    logic [CTL_W-1:0] ctl_s2;
  } frame_t;

  // Survives deselection so the core can commit after select rises
  typedef struct packed {
    logic                     tag;
    commit_t                  op;
    logic                     aligned;
    logic [ADDR_W-1:0]        addr;
    logic                     id_sel;
    logic [CNT_W-1:0]         nbytes;
    logic [ID_WORDS-1:0][7:0] page;
  } held_t;

  typedef struct packed {
    logic q;
    logic oe_n;
  } out_t;

  frame_t      f_r;
  frame_t      f_nxt;
  held_t       h_r;
  held_t       h_nxt;
  out_t        o_r;
  out_t        o_nxt;
  logic [7:0]  byte_in;
  logic [15:0] a_next;
  logic [15:0] a_inc;
  logic        q_off;

  // Pause and deselect both float the output at once, not at a clock edge
  assign q_off = cs_n | ~hold_n | held_rst;

  always_comb begin
    f_nxt   = f_r;
    h_nxt   = h_r;
    byte_in = {f_r.sh[6:0], di};
    a_next  = f_r.a16;
    a_inc   = f_r.a16 + 16'h0001;
    rd_addr = f_r.a16[ADDR_W-1:0];
    rd_id   = f_r.id_sel;
    // Hold level is stable across the rising edge, so it is sampled directly
    if (hold_n) begin
      if (!f_r.started) begin
        f_nxt.started = 1'b1;
        h_nxt.tag     = ~h_r.tag;
        h_nxt.op      = COMMIT_NONE;
        h_nxt.nbytes  = '0;
      end
      f_nxt.ctl_s1  = ctl;
      f_nxt.ctl_s2  = f_r.ctl_s1;
      f_nxt.sh      = byte_in;
      f_nxt.bitpos  = f_r.bitpos + 3'h1;
      h_nxt.aligned = (f_r.bitpos == 3'h7);
      if (f_r.bitpos == 3'h7) begin
        case (f_r.phase)
          PH_CMD: begin
            f_nxt.opcode = byte_in;
            f_nxt.phase  = PH_IGNORE;
            f_nxt.id_sel = (byte_in == OP_RD_ID) || (byte_in == OP_WR_ID);
            if (!f_r.ctl_s2[CTL_ARMED]) begin
              f_nxt.phase = PH_IGNORE;
            end else if (byte_in == OP_RDSR) begin
              f_nxt.out_byte = f_r.ctl_s2[7:0];
              f_nxt.phase    = PH_STATUS_OUT;
            end else if (!f_r.ctl_s2[ST_WIP]) begin
              case (byte_in)
                OP_WREN:  h_nxt.op    = COMMIT_WREN;
                OP_WRDI:  h_nxt.op    = COMMIT_WRDI;
                OP_WRSR:  f_nxt.phase = PH_DATA_IN;
                OP_READ,
                OP_WRITE,
                OP_RD_ID,
                OP_WR_ID: f_nxt.phase = PH_ADDR;
                default:  f_nxt.phase = PH_IGNORE;
              endcase
            end
          end
          PH_ADDR: begin
            a_next             = {f_r.a16[7:0], byte_in};
            f_nxt.a16          = a_next;
            f_nxt.addr_hi_done = 1'b1;
            if (f_r.addr_hi_done) begin
              rd_addr        = a_next[ADDR_W-1:0];
              f_nxt.out_byte = rd_byte;
              f_nxt.col      = a_next[COL_W-1:0];
              h_nxt.addr     = a_next[ADDR_W-1:0];
              h_nxt.id_sel   = f_r.id_sel;
              if (f_r.opcode == OP_READ || f_r.opcode == OP_RD_ID) begin
                f_nxt.phase = PH_DATA_OUT;
              end else begin
                f_nxt.phase = PH_DATA_IN;
                if (!f_r.id_sel) begin
                  h_nxt.op = COMMIT_WRITE;
                end else if (a_next[LOCK_ADDR_BIT]) begin
                  h_nxt.op = COMMIT_LOCK;
                end else begin
                  h_nxt.op = COMMIT_WR_ID;
                end
              end
            end
          end
          PH_DATA_IN: begin
            // Bytes beyond a page wrap to its start and overwrite
            h_nxt.page[f_r.col] = byte_in;
            f_nxt.col           = f_r.col + 5'h01;
            if (h_r.nbytes != CNT_W'(ID_WORDS)) begin
              h_nxt.nbytes = h_r.nbytes + 6'h01;
            end
            if (f_r.opcode == OP_WRSR) begin
              h_nxt.op    = COMMIT_WRSR;
              f_nxt.phase = PH_IGNORE;
            end
          end
          PH_DATA_OUT: begin
            if (f_r.id_sel) begin
              a_next = {f_r.a16[15:COL_W], a_inc[COL_W-1:0]};
            end else begin
              a_next = {4'h0, a_inc[ADDR_W-1:0]};
            end
            f_nxt.a16      = a_next;
            rd_addr        = a_next[ADDR_W-1:0];
            f_nxt.out_byte = rd_byte;
          end
          PH_STATUS_OUT: f_nxt.out_byte = f_r.ctl_s2[7:0];
          default:       f_nxt.phase    = PH_IGNORE;
        endcase
      end
    end
    o_nxt.q    = f_r.out_byte[~f_r.bitpos];
    o_nxt.oe_n = !(f_r.phase == PH_DATA_OUT || f_r.phase == PH_STATUS_OUT);
  end

  // Select high clears the frame, also while paused
  // Core reset stands in for power-up, when select may never have been high
  always_ff @(posedge spi_clk or posedge cs_n or posedge held_rst) begin
    if (cs_n || held_rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge spi_clk or posedge held_rst) begin
    if (held_rst) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  // Pause only gates the enable, so the held bit drives again once it ends
  always_ff @(negedge spi_clk or posedge cs_n or posedge held_rst) begin
    if (cs_n || held_rst) begin
      o_r <= 2'b01;
    end else begin
      o_r <= o_nxt;
    end
  end

  assign tag     = h_r.tag;
  assign op      = h_r.op;
  assign aligned = h_r.aligned;
  assign wr_addr = h_r.addr;
  assign wr_id   = h_r.id_sel;
  assign nbytes  = h_r.nbytes;
  assign page    = h_r.page;
  assign q       = o_r.q;
  assign q_oe_n  = o_r.oe_n | q_off;

endmodule

module eeprom_spi_top
  import eeprom_spi_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES,
  parameter int STEP_CYCLES    = WRITE_STEP_CYCLES,
  parameter int BUF_DEPTH      = WBUF_DEPTH
) (
  input  wire logic CORE_CLK,
  input  wire logic RESET_N,
  input  wire logic SPI_CLK,
  input  wire logic SPI_CS_N,
  input  wire logic SPI_DI,
  input  wire logic SPI_HOLD_N,
  input  wire logic SPI_WP_N,
  output logic      SPI_DO,
  output logic      SPI_DO_OE_N,
  output logic      POWER_ACTIVE,
  output logic      WRITE_BUSY
);

  localparam int TIMER_W = $clog2(WRITE_CYCLES_P + 1);
  localparam int STEP_W  = $clog2(STEP_CYCLES + 1);
  localparam int BCNT_W  = $clog2(BUF_DEPTH + 1);

  typedef struct packed {
    logic                           link_rst;
    logic                           cs_s1;
    logic                           cs_s2;
    logic                           cs_d;
    logic                           wp_s1;
    logic                           wp_s2;
    logic                           armed;
    logic                           wel;
    logic [1:0]                     guard;
    logic                           locked;
    logic                           last_tag;
    logic [TIMER_W-1:0]             timer;
    logic                           feeding;
    logic [CNT_W-1:0]               feed_idx;
    logic [CNT_W-1:0]               feed_len;
    logic [BUF_DEPTH-1:0][$bits(wr_word_t)-1:0] buf_q;
    logic [BCNT_W-1:0]              buf_cnt;
    logic [STEP_W-1:0]              step;
    logic                           power_active;
    logic                           busy;
  } core_t;

  core_t                    r;
  core_t                    n;
  logic [7:0]               mem [ARRAY_WORDS];
  logic [7:0]               idmem [ID_WORDS];
  logic [ADDR_W-1:0]        rd_addr;
  logic                     rd_id;
  logic [7:0]               rd_byte;
  logic                     link_tag;
  commit_t                  link_op;
  logic                     link_aligned;
  logic [ADDR_W-1:0]        link_addr;
  logic                     link_id;
  logic [CNT_W-1:0]         link_nbytes;
  logic [ID_WORDS-1:0][7:0] link_page;
  logic [CTL_W-1:0]         ctl;
  logic                     push_valid;
  logic                     push_ready;
  logic                     pop_valid;
  logic                     pop_ready;
  wr_word_t                 head;
  wr_word_t                 push_word;
  logic [COL_W-1:0]         col_i;
  logic [BCNT_W-1:0]        cnt;
  logic                     ok;

  function automatic logic guarded(input logic [1:0] g, input logic [ADDR_W-1:0] a);
    case (g)
      2'h1:    guarded = &a[ADDR_W-1:ADDR_W-2];
      2'h2:    guarded = a[ADDR_W-1];
      2'h3:    guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  assign ctl = {r.armed, r.locked, 4'h0, r.guard, r.wel, r.busy};

  // Reads are refused while a write runs, so the array is quiet when read here
  assign rd_byte = rd_id ? idmem[rd_addr[COL_W-1:0]] : mem[rd_addr];

  eeprom_spi_link u_link (
    .spi_clk  (SPI_CLK),
    .cs_n     (SPI_CS_N),
    .hold_n   (SPI_HOLD_N),
    .di       (SPI_DI),
    .held_rst (r.link_rst),
    .ctl      (ctl),
    .rd_byte  (rd_byte),
    .rd_addr  (rd_addr),
    .rd_id    (rd_id),
    .tag      (link_tag),
    .op       (link_op),
    .aligned  (link_aligned),
    .wr_addr  (link_addr),
    .wr_id    (link_id),
    .nbytes   (link_nbytes),
    .page     (link_page),
    .q        (SPI_DO),
    .q_oe_n   (SPI_DO_OE_N)
  );

  always_comb begin
    n          = r;
    n.link_rst = 1'b0;
    n.cs_s1    = SPI_CS_N;
    n.cs_s2    = r.cs_s1;
    n.cs_d     = r.cs_s2;
    n.wp_s1    = SPI_WP_N;
    n.wp_s2    = r.wp_s1;
    // A low select at power-up does not count: a high must be seen first
    if (r.cs_d && !r.cs_s2) begin
      n.armed = 1'b1;
    end
    if (r.timer != '0) begin
      n.timer = r.timer - TIMER_W'(1);
    end
    // Drain side of the write buffer: paced by the programming step
    head      = wr_word_t'(r.buf_q[0]);
    pop_valid = (r.buf_cnt != '0);
    pop_ready = (r.step == '0);
    cnt       = r.buf_cnt;
    if (r.step != '0) begin
      n.step = r.step - STEP_W'(1);
    end
    if (pop_valid && pop_ready) begin
      n.step = STEP_W'(STEP_CYCLES - 1);
      for (int i = 0; i < BUF_DEPTH - 1; i++) begin
        n.buf_q[i] = r.buf_q[i + 1];
      end
      cnt = cnt - BCNT_W'(1);
    end
    // Fill side: ready only while not full, so the feeder stalls
    col_i      = COL_W'(link_addr[COL_W-1:0] + r.feed_idx[COL_W-1:0]);
    push_word  = '{id: link_id, addr: {link_addr[ADDR_W-1:COL_W], col_i},
                   data: link_page[col_i]};
    push_valid = r.feeding;
    push_ready = (r.buf_cnt != BCNT_W'(BUF_DEPTH));
    if (push_valid && push_ready) begin
      n.buf_q[cnt] = push_word;
      cnt          = cnt + BCNT_W'(1);
      n.feed_idx   = r.feed_idx + 6'h01;
      if (r.feed_idx + 6'h01 == r.feed_len) begin
        n.feeding = 1'b0;
      end
    end
    n.buf_cnt = cnt;
    // Link fields are frozen while select is high, so they are read here
    ok = r.wel && link_aligned && (link_nbytes != '0);
    if (r.cs_s2 && !r.cs_d && (link_tag != r.last_tag)) begin
      n.last_tag = link_tag;
      // Unarmed frames still flip the tag; they resync it but commit nothing
      case (r.armed ? link_op : COMMIT_NONE)
        COMMIT_WREN: n.wel = 1'b1;
        COMMIT_WRDI: n.wel = 1'b0;
        COMMIT_WRSR: begin
          if (ok) begin
            if (r.wp_s2) begin
              n.guard = link_page[0][ST_GUARD_HI:ST_GUARD_LO];
            end
            n.wel   = 1'b0;
            n.timer = TIMER_W'(WRITE_CYCLES_P);
          end
        end
        COMMIT_WRITE,
        COMMIT_WR_ID: begin
          if (ok && (link_id ? !r.locked : !guarded(r.guard, link_addr))) begin
            n.feeding  = 1'b1;
            n.feed_idx = '0;
            // A status poll during the cycle clears the link count, so keep a copy
            n.feed_len = link_nbytes;
            n.wel      = 1'b0;
            n.timer    = TIMER_W'(WRITE_CYCLES_P);
          end
        end
        COMMIT_LOCK: begin
          if (ok && !r.locked) begin
            n.locked = 1'b1;
            n.wel    = 1'b0;
            n.timer  = TIMER_W'(WRITE_CYCLES_P);
          end
        end
        default: n.last_tag = link_tag;
      endcase
    end
    n.busy         = (n.timer != '0) || n.feeding || (n.buf_cnt != '0);
    n.power_active = !r.cs_s2 || n.busy;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      r          <= '0;
      r.link_rst <= 1'b1;
      r.guard    <= GUARD_RST;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (pop_valid && pop_ready) begin
      if (head.id) begin
        idmem[head.addr[COL_W-1:0]] <= head.data;
      end else begin
        mem[head.addr] <= head.data;
      end
    end
  end

  assign POWER_ACTIVE = r.power_active;
  assign WRITE_BUSY   = r.busy;

endmodule

// file: spi_eeprom_pin_interface_assertions.sv
// Pin-level checks for the serial EEPROM, seen from the top ports only.
// Assumes a bind into eeprom_spi_top that hands on the write length.
`timescale 1ns/1ns

module spi_eeprom_pin_interface_assertions #(
  parameter int WRITE_CYCLES_P = 50
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic SPI_CLK,
  input wire logic SPI_CS_N,
  input wire logic SPI_HOLD_N,
  input wire logic SPI_DO,
  input wire logic SPI_DO_OE_N,
  input wire logic POWER_ACTIVE,
  input wire logic WRITE_BUSY
);
  int   busy_cnt;
  logic do_rise;

  always_ff @(posedge CORE_CLK) begin
    busy_cnt <= (!RESET_N || !WRITE_BUSY) ? 0 : busy_cnt + 1;
  end

  // Level seen at each rise; it may only move at the next fall
  always_ff @(posedge SPI_CLK) begin
    do_rise <= SPI_DO;
  end

  AST_DESEL_FLOAT: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    SPI_CS_N && $past(SPI_CS_N) |-> SPI_DO_OE_N) else $error("output driven when deselected");
  AST_PAUSE_FLOAT: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    !SPI_HOLD_N && !$past(SPI_HOLD_N) |-> SPI_DO_OE_N) else $error("output driven in pause");
  AST_DO_ON_FALL: assert property (@(negedge SPI_CLK)
    disable iff (!RESET_N || SPI_CS_N || !SPI_HOLD_N) SPI_DO == do_rise)
    else $error("output moved on a rising edge");
  AST_SEL_ACTIVE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (!SPI_CS_N) [*4] |-> POWER_ACTIVE) else $error("selected but in standby");
  AST_STANDBY: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (SPI_CS_N && !WRITE_BUSY) [*5] |-> !POWER_ACTIVE) else $error("idle but not in standby");
  AST_BUSY_ACTIVE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    WRITE_BUSY && $past(WRITE_BUSY) |-> POWER_ACTIVE) else $error("standby during write");
  AST_BUSY_LEN: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $fell(WRITE_BUSY) |-> busy_cnt == WRITE_CYCLES_P) else $error("write cycle length wrong");
  AST_WRITE_ON_DESEL: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(WRITE_BUSY) |-> SPI_CS_N && $past(SPI_CS_N)) else $error("write began while selected");

  COV_WRITE: cover property (@(posedge CORE_CLK) $rose(WRITE_BUSY));
  COV_PAUSE: cover property (@(posedge CORE_CLK) !SPI_HOLD_N && !SPI_CS_N);
  COV_READ: cover property (@(posedge CORE_CLK) !SPI_DO_OE_N);
endmodule

// file: spi_eeprom_pin_interface_tb.sv
// Self-checking bench for the serial EEPROM pin interface.
// Assumes the package, master model and checker are compiled before it.
`timescale 1ns/1ns

module spi_eeprom_pin_interface_tb;
  import eeprom_spi_pkg::*;

  localparam int WCYC = 50;

  logic core_clk;
  logic reset_n;
  logic wp_n;
  wire  sclk;
  wire  cs_n;
  wire  di;
  wire  hold_n;
  wire  do_line;
  wire  do_oe_n;
  wire  power_active;
  wire  write_busy;
  int   errors;
  int   comparisons;

  eeprom_spi_top #(.WRITE_CYCLES_P(WCYC)) DUT (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .SPI_CLK(sclk), .SPI_CS_N(cs_n),
    .SPI_DI(di), .SPI_HOLD_N(hold_n), .SPI_WP_N(wp_n), .SPI_DO(do_line),
    .SPI_DO_OE_N(do_oe_n), .POWER_ACTIVE(power_active), .WRITE_BUSY(write_busy));

  spi_master_model m (
    .sclk(sclk), .cs_n(cs_n), .di(di), .hold_n(hold_n), .do_line(do_line), .do_oe_n(do_oe_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_busy(input logic lvl);
    for (int n = 0; write_busy !== lvl; n++) begin
      @(negedge core_clk);
      if (n > 400) begin
        check({7'h0, write_busy}, {7'h0, lvl});
        close_out();
      end
    end
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] rx;
    m.bits(b, 7, 0, rx);
  endtask

  task automatic hdr(input logic [7:0] op, input logic [11:0] a);
    m.select();
    send(op);
    send({4'h0, a[11:8]});
    send(a[7:0]);
  endtask

  task automatic cmd(input logic [7:0] op);
    m.select();
    send(op);
    m.deselect();
  endtask

  // Mask hides status bits a scenario does not own
  task automatic status_is(input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] rx;
    m.select();
    send(OP_RDSR);
    m.bits(8'h00, 7, 0, rx);
    m.deselect();
    check(rx & mask, exp);
  endtask

  task automatic read_is(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] rx;
    hdr(OP_READ, a);
    m.bits(8'h00, 7, 0, rx);
    m.deselect();
    check(rx, exp);
  endtask

  task automatic wrsr(input logic [7:0] v);
    cmd(OP_WREN);
    m.select();
    send(OP_WRSR);
    send(v);
    m.deselect();
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask

  task automatic t_first_select();
    send(OP_WREN);
    m.deselect();
    status_is(8'h00, 8'hFF);
    cmd(OP_WREN);
    status_is(8'h02, 8'hFF);
    $display("test first_select done");
  endtask

  task automatic t_write_read();
    cmd(OP_WREN);
    hdr(OP_WRITE, 12'h0FE);
    send(8'hA5);
    send(8'h3C);
    send(8'h96);
    m.deselect();
    check({7'h0, m.drove}, 8'h00);
    wait_busy(1'b1);
    check({7'h0, power_active}, 8'h01);
    status_is(8'h01, 8'h01);
    wait_busy(1'b0);
    repeat (3) @(negedge core_clk);
    check({7'h0, power_active}, 8'h00);
    read_is(12'h0FE, 8'hA5);
    read_is(12'h0E0, 8'h96);
    check({7'h0, do_oe_n}, 8'h01);
    $display("test write_read done");
  endtask

  task automatic t_pause();
    logic [7:0] hi;
    logic [7:0] lo;
    hdr(OP_READ, 12'h0FE);
    m.bits(8'h00, 7, 4, hi);
    m.pause();
    check({7'h0, do_oe_n}, 8'h01);
    m.resume();
    m.bits(8'h00, 3, 0, lo);
    check({hi[7:4], lo[3:0]}, 8'hA5);
    m.bits(8'h00, 7, 0, lo);
    check(lo, 8'h3C);
    m.deselect();
    $display("test pause done");
  endtask

  // A half-shifted opcode left behind would skew the next frame
  task automatic t_pause_desel();
    logic [7:0] rx;
    m.select();
    m.bits(OP_WRITE, 7, 4, rx);
    m.pause();
    m.deselect();
    m.resume();
    read_is(12'h0FE, 8'hA5);
    $display("test pause_desel done");
  endtask

  task automatic t_protect();
    wrsr(8'h0C);
    status_is(8'h0C, 8'h0D);
    @(posedge core_clk);
    #1 wp_n = 1'b0;
    wrsr(8'h00);
    status_is(8'h0C, 8'h0D);
    cmd(OP_WREN);
    hdr(OP_WRITE, 12'h000);
    send(8'h11);
    m.deselect();
    check({7'h0, write_busy}, 8'h00);
    @(posedge core_clk);
    #1 wp_n = 1'b1;
    wrsr(8'h00);
    status_is(8'h00, 8'h0D);
    $display("test protect done");
  endtask

  task automatic write1(input logic [7:0] op, input logic [11:0] a, input logic [7:0] d);
    cmd(OP_WREN);
    hdr(op, a);
    send(d);
    m.deselect();
  endtask

  task automatic id_read_is(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] rx;
    hdr(OP_RD_ID, a);
    m.bits(8'h00, 7, 0, rx);
    m.deselect();
    check(rx, exp);
  endtask

  // Lock makes the page read-only; the refused write leaves the enable latch set
  task automatic t_id_page();
    write1(OP_WR_ID, 12'h005, 8'h5A);
    wait_busy(1'b1);
    wait_busy(1'b0);
    id_read_is(12'h005, 8'h5A);
    write1(OP_WR_ID, 12'h400, 8'h00);
    wait_busy(1'b1);
    wait_busy(1'b0);
    write1(OP_WR_ID, 12'h005, 8'h77);
    check({7'h0, write_busy}, 8'h00);
    id_read_is(12'h005, 8'h5A);
    cmd(OP_WRDI);
    status_is(8'h00, 8'h02);
    $display("test id_page done");
  endtask

  initial begin
    reset_n     = 1'b0;
    wp_n        = 1'b1;
    errors      = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (8) @(posedge core_clk);
    t_first_select();
    t_write_read();
    t_pause();
    t_pause_desel();
    t_protect();
    t_id_page();
    close_out();
  end
endmodule

bind eeprom_spi_top spi_eeprom_pin_interface_assertions #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SPI_CLK(SPI_CLK), .SPI_CS_N(SPI_CS_N),
  .SPI_HOLD_N(SPI_HOLD_N), .SPI_DO(SPI_DO), .SPI_DO_OE_N(SPI_DO_OE_N),
  .POWER_ACTIVE(POWER_ACTIVE), .WRITE_BUSY(WRITE_BUSY));

// file: spi_master_model.sv
// Mode 0 SPI master model driving the serial EEPROM pins.
// Assumes one task runs at a time; the clock idles low between frames.
`timescale 1ns/1ns

module spi_master_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      di,
  output logic      hold_n,
  input  wire logic do_line,
  input  wire logic do_oe_n
);
  logic drove;

  // Select starts low on purpose: no falling edge yet since power-up
  initial begin
    sclk   = 1'b0;
    cs_n   = 1'b0;
    di     = 1'b0;
    hold_n = 1'b1;
    drove  = 1'b0;
  end

  task automatic select();
    cs_n  = 1'b0;
    drove = 1'b0;
    #243;
  endtask

  // Data line flips on release so no stale level lingers
  task automatic deselect();
    #16;
    cs_n = 1'b1;
    di   = ~di;
    #200;
  endtask

  // Reads the device just before each rise, after its falling-edge update
  task automatic bits(input logic [7:0] tx, input int hi, input int lo, output logic [7:0] rx);
    for (int i = hi; i >= lo; i--) begin
      di = tx[i];
      #16;
      // A floating line reads inverted, so a late or missing driver shows
      rx[i] = do_oe_n ? ~do_line : do_line;
      drove = drove | ~do_oe_n;
      sclk  = 1'b1;
      #16;
      sclk = 1'b0;
    end
  endtask

  // Clock and data keep moving in the pause; the device must ignore them
  task automatic pause();
    #8;
    hold_n = 1'b0;
    repeat (3) begin
      #16;
      di   = ~di;
      sclk = 1'b1;
      #16;
      sclk = 1'b0;
    end
  endtask

  task automatic resume();
    #16;
    hold_n = 1'b1;
    #16;
  endtask
endmodule
